// file: hdl/ufc_flow_ctrl.sv
/*
  One serial channel with 64-deep FIFOs, hardware and in-band flow control,
  special-character detection and an AHB-Lite register slave.
  Assumes a single-slave AHB-Lite bus on hclk; serial pins are asynchronous
  and pass two flip-flops before use.
*/
// Design decisions made here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
// How it works
// - both FIFOs hold 64 characters; receive entries carry three error bits
// - FIFOs start disabled so every trigger level is one character
// - two separate feature bits enable automatic CTS and automatic RTS
// - with auto CTS, a new character starts only while CTS is low
// - with auto CTS enabled, CTS changes raise no interrupt
// - without auto CTS, queued characters are sent regardless of CTS
// - auto RTS holds RTS active below the halt level, drops at it
// - after a halt, auto RTS returns when level falls to resume
// - one extra character after RTS drops is stored, not an error
// - upper selection bits pick which pause/resume pairs are transmitted
// - lower selection bits pick receive comparison, both bits means sequence
// - resume-on-any-character option; that character is not stored
// - special character sets the pause flag, is stored, ident read clears
// - pause character halts after current character and flags interrupt
// - resume character restarts transmission and clears the pause flag
// - pause characters are sent once receive level passes halt level
// - resume characters are sent when receive level falls to resume
// - flow characters framed like data; only word-length low bits sent
// - baud divisor is 16 bits, usable from one to all ones
// - modem RTS bit drives RTS low; RTS high after reset
// - pause interrupt code 10h, CTS/RTS inactive code 20h, that priority
module ufc_flow_ctrl import ufc_pkg::*; #(
  parameter int FIFO_DEPTH = 64
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic rx_in,
  input wire logic clear_to_send_n,
  output logic tx_out,
  output logic request_to_send_n,
  output logic channel_irq,
  output logic rx_ready_n,
  output logic tx_ready_n
);
  localparam int AW = $clog2(FIFO_DEPTH);

  if (FIFO_DEPTH < 4 || FIFO_DEPTH > 128 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_chk
    $error("FIFO_DEPTH must be a power of two from 4 to 128");
  end

  typedef struct packed {
    logic [FIFO_DEPTH-1:0][7:0] tx_mem;
    logic [AW-1:0] tx_rd, tx_wr;
    logic [AW:0] tx_cnt;
    ufc_rx_entry_t [FIFO_DEPTH-1:0] rx_mem;
    logic [AW-1:0] rx_rd, rx_wr;
    logic [AW:0] rx_cnt;
    logic fifo_en;
    logic [7:0] interrupt_enable_ctrl, lcr, modem_ctrl, enhanced_feature_ctrl, flow_threshold_ctrl, fifo_level_select;
    logic [15:0] div;
    ufc_chars_t chars;
    logic [31:0] rdata;
    logic ap_valid, ap_write, rd_wait;
    logic [7:0] ap_addr;
    logic [1:0] rx_s, cts_s;
    logic cts_q;
    ufc_ser_t tx_st, rx_st;
    logic [UFC_BCW-1:0] tx_bc, rx_bc;
    logic [2:0] tx_bit, rx_bit;
    logic [7:0] tx_sh, rx_sh;
    logic tx_line, rts_on, rts_n, irq, rxr_n, txr_n;
    logic sw_halt, xoff_seen, xon_seen, xoff_sent, fl_second;
    ufc_flow_t fl_pend;
    logic xoff_flag, cts_flag;
  } ufc_state_t;

  ufc_state_t s, n;
  logic rx_push, rx_pop, tx_push, tx_pop, rx_done;
  logic xoff_hit, xon_hit, any_hit, special, seq_first, tx_block, cts_ok;
  logic [7:0] rx_lvl, halt_lvl, resume_lvl, cap;
  logic [UFC_BCW-1:0] blen;
  logic [2:0] wl;
  ufc_rx_entry_t rx_ent;
  ufc_stat_t stat;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [7:0] lvl(input logic [3:0] nib);
    lvl = 8'({4'h0, nib} << UFC_LVL_SHIFT);
  endfunction

  function automatic logic [7:0] trig(input logic en, input logic [3:0] nib);
    trig = (!en || nib == 4'h0) ? UFC_TRIG_ONE : lvl(nib);
  endfunction

  function automatic logic [7:0] flow_char(input ufc_flow_t p, input logic sec,
                                          input ufc_chars_t c);
    if (p == UFC_FL_XOFF) begin
      flow_char = sec ? c.pause_char_second : c.pause_char_first;
    end else begin
      flow_char = sec ? c.resume_char_second : c.resume_char_first;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // derived levels; divisor zero is served as one
  assign rx_lvl = 8'(s.rx_cnt);
  assign halt_lvl = lvl(s.flow_threshold_ctrl[3:0]);
  assign resume_lvl = lvl(s.flow_threshold_ctrl[7:4]);
  assign cap = s.fifo_en ? 8'(FIFO_DEPTH) : UFC_TRIG_ONE;
  assign blen = (UFC_BCW'((s.div == 16'h0) ? UFC_DIV_MIN : s.div) << UFC_OS_SHIFT)
                - UFC_BCW'(1);
  assign wl = UFC_WL_BASE + {1'b0, s.lcr[1:0]};
  // in-band halt only counts while receive comparison is on
  assign tx_block = s.sw_halt && s.enhanced_feature_ctrl[1:0] != 2'b00;
  assign cts_ok = !(s.enhanced_feature_ctrl[UFC_EFR_ACTS] && s.cts_s[1]);
  assign hreadyout = !(s.ap_valid && !s.ap_write && !s.rd_wait);
  assign hresp = 1'b0;
  assign hrdata = s.rdata;
  assign tx_out = s.tx_line;
  assign request_to_send_n = s.rts_n;
  assign channel_irq = s.irq;
  assign rx_ready_n = s.rxr_n;
  assign tx_ready_n = s.txr_n;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    n = s;
    rx_push = 1'b0;
    rx_pop = 1'b0;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    rx_done = 1'b0;
    xoff_hit = 1'b0;
    xon_hit = 1'b0;
    any_hit = 1'b0;
    special = 1'b0;
    seq_first = 1'b0;
    rx_ent = '0;
    stat = '0;
    // only the second stage of each synchroniser is read
    n.rx_s = {s.rx_s[0], rx_in};
    n.cts_s = {s.cts_s[0], clear_to_send_n};
    n.cts_q = s.cts_s[1];

    // bus: reads wait one cycle so read data comes from a flop
    if (s.ap_valid && !s.ap_write && !s.rd_wait) begin
      n.rd_wait = 1'b1;
      n.rdata = '0;
      unique case (s.ap_addr)
        UFC_A_DATA: begin
          n.rdata = 32'(s.rx_mem[s.rx_rd]);
          rx_pop = s.rx_cnt != '0;
        end
        UFC_A_IER: n.rdata = 32'(s.interrupt_enable_ctrl);
        UFC_A_IIR: begin
          if (s.xoff_flag && s.interrupt_enable_ctrl[UFC_IER_XOFF]) begin
            n.rdata = 32'(UFC_IIR_XOFF);
            n.xoff_flag = 1'b0;
          end else if (s.cts_flag && s.interrupt_enable_ctrl[UFC_IER_CTSRTS]) begin
            n.rdata = 32'(UFC_IIR_CTSRTS);
            n.cts_flag = 1'b0;
          end else begin
            n.rdata = 32'(UFC_IIR_NONE);
          end
        end
        UFC_A_LCR: n.rdata = 32'(s.lcr);
        UFC_A_MCR: n.rdata = 32'(s.modem_ctrl);
        UFC_A_EFR: n.rdata = 32'(s.enhanced_feature_ctrl);
        UFC_A_TCR: n.rdata = 32'(s.flow_threshold_ctrl);
        UFC_A_TLR: n.rdata = 32'(s.fifo_level_select);
        UFC_A_DIV: n.rdata = 32'(s.div);
        UFC_A_CHR: n.rdata = 32'(s.chars);
        UFC_A_STAT: begin
          stat.rts_pin_n = s.rts_n;
          stat.cts_pin_n = s.cts_s[1];
          stat.tx_halted = tx_block;
          stat.tx_level = 8'(s.tx_cnt);
          stat.rx_level = rx_lvl;
          n.rdata = 32'(stat);
        end
        default: n.rdata = '0;
      endcase
    end else if (hready) begin
      n.rd_wait = 1'b0;
      n.ap_valid = hsel && htrans == UFC_HTRANS_NONSEQ && hsize == UFC_HSIZE_WORD;
      n.ap_write = hwrite;
      n.ap_addr = haddr[7:0];
      if (s.ap_valid && s.ap_write) begin
        unique case (s.ap_addr)
          UFC_A_DATA: tx_push = 8'(s.tx_cnt) < cap;
          UFC_A_IER: n.interrupt_enable_ctrl = 8'(hwdata);
          UFC_A_IIR: n.fifo_en = hwdata[UFC_FCR_EN];
          UFC_A_LCR: n.lcr = 8'(hwdata);
          UFC_A_MCR: n.modem_ctrl = 8'(hwdata);
          UFC_A_EFR: n.enhanced_feature_ctrl = 8'(hwdata);
          UFC_A_TCR: n.flow_threshold_ctrl = 8'(hwdata);
          UFC_A_TLR: n.fifo_level_select = 8'(hwdata);
          UFC_A_DIV: n.div = 16'(hwdata);
          UFC_A_CHR: n.chars = ufc_chars_t'(hwdata);
          default: n.flow_threshold_ctrl = s.flow_threshold_ctrl;
        endcase
      end
    end

    // receiver: half-bit check of start, then one sample per bit time
    if (s.rx_bc != '0) begin
      n.rx_bc = s.rx_bc - UFC_BCW'(1);
    end
    unique case (s.rx_st)
      UFC_IDLE: if (!s.rx_s[1]) begin
        n.rx_st = UFC_START;
        n.rx_bc = blen >> 1;
      end
      UFC_START: if (s.rx_bc == '0) begin
        n.rx_st = s.rx_s[1] ? UFC_IDLE : UFC_DATA;
        n.rx_bc = blen;
        n.rx_bit = '0;
        n.rx_sh = '0;
      end
      UFC_DATA: if (s.rx_bc == '0) begin
        n.rx_sh[s.rx_bit] = s.rx_s[1];
        n.rx_bit = s.rx_bit + 3'h1;
        n.rx_bc = blen;
        if (s.rx_bit == wl) begin
          n.rx_st = UFC_STOP;
        end
      end
      UFC_STOP: if (s.rx_bc == '0) begin
        n.rx_st = UFC_IDLE;
        rx_done = 1'b1;
      end
    endcase
    rx_ent.data = s.rx_sh;
    rx_ent.err_frame = !s.rx_s[1];
    rx_ent.err_break = !s.rx_s[1] && s.rx_sh == '0;

    // in-band receive comparison
    if (rx_done) begin
      unique case (s.enhanced_feature_ctrl[1:0])
        2'b10: begin
          xoff_hit = s.rx_sh == s.chars.pause_char_first;
          xon_hit = s.rx_sh == s.chars.resume_char_first;
        end
        2'b01: begin
          xoff_hit = s.rx_sh == s.chars.pause_char_second;
          xon_hit = s.rx_sh == s.chars.resume_char_second;
        end
        2'b11: begin
          xoff_hit = s.xoff_seen && s.rx_sh == s.chars.pause_char_second;
          xon_hit = s.xon_seen && s.rx_sh == s.chars.resume_char_second;
          seq_first = s.rx_sh == s.chars.pause_char_first
                      || s.rx_sh == s.chars.resume_char_first;
        end
        default: seq_first = 1'b0;
      endcase
      n.xoff_seen = s.enhanced_feature_ctrl[1:0] == 2'b11 && s.rx_sh == s.chars.pause_char_first;
      n.xon_seen = s.enhanced_feature_ctrl[1:0] == 2'b11 && s.rx_sh == s.chars.resume_char_first;
      any_hit = tx_block && s.modem_ctrl[UFC_MCR_XANY] && !xoff_hit;
      special = s.enhanced_feature_ctrl[UFC_EFR_SPECIAL] && !xoff_hit
                && s.rx_sh == s.chars.pause_char_second;
      if (xon_hit || any_hit) begin
        n.sw_halt = 1'b0;
        n.xoff_flag = 1'b0;
      end
      // set after the ident-read clear so a coincident event wins
      if (xoff_hit) begin
        n.sw_halt = 1'b1;
        n.xoff_flag = s.interrupt_enable_ctrl[UFC_IER_XOFF] || n.xoff_flag;
      end
      if (special && s.interrupt_enable_ctrl[UFC_IER_XOFF]) begin
        n.xoff_flag = 1'b1;
      end
      // stored while room remains, also the one after RTS drops
      rx_push = !(xoff_hit || xon_hit || any_hit || seq_first)
                && rx_lvl < cap;
    end

    // auto RTS hysteresis between halt and resume levels
    if (rx_lvl >= halt_lvl) begin
      n.rts_on = 1'b0;
    end else if (rx_lvl <= resume_lvl) begin
      n.rts_on = 1'b1;
    end
    n.rts_n = s.enhanced_feature_ctrl[UFC_EFR_ARTS] ? !s.rts_on : !s.modem_ctrl[UFC_MCR_RTS];

    // in-band transmit requests
    if (s.enhanced_feature_ctrl[3:2] != 2'b00) begin
      if (!s.xoff_sent && rx_lvl > halt_lvl) begin
        n.xoff_sent = 1'b1;
        n.fl_pend = UFC_FL_XOFF;
        n.fl_second = s.enhanced_feature_ctrl[3:2] == 2'b01;
      end else if (s.xoff_sent && rx_lvl <= resume_lvl) begin
        n.xoff_sent = 1'b0;
        n.fl_pend = UFC_FL_XON;
        n.fl_second = s.enhanced_feature_ctrl[3:2] == 2'b01;
      end
    end

    // transmitter: flow characters go ahead of queued data
    if (s.tx_bc != '0) begin
      n.tx_bc = s.tx_bc - UFC_BCW'(1);
    end
    unique case (s.tx_st)
      UFC_IDLE: if (cts_ok && (s.fl_pend != UFC_FL_NONE
                               || (s.tx_cnt != '0 && !tx_block))) begin
        n.tx_st = UFC_START;
        n.tx_bc = blen;
        n.tx_line = 1'b0;
        if (s.fl_pend != UFC_FL_NONE) begin
          n.tx_sh = flow_char(s.fl_pend, s.fl_second, s.chars);
          if (s.enhanced_feature_ctrl[3:2] == 2'b11 && !s.fl_second) begin
            n.fl_second = 1'b1;
          end else begin
            n.fl_pend = UFC_FL_NONE;
          end
        end else begin
          n.tx_sh = s.tx_mem[s.tx_rd];
          tx_pop = 1'b1;
        end
      end
      UFC_START: if (s.tx_bc == '0) begin
        n.tx_st = UFC_DATA;
        n.tx_bc = blen;
        n.tx_bit = '0;
        n.tx_line = s.tx_sh[0];
      end
      UFC_DATA: if (s.tx_bc == '0) begin
        n.tx_bc = blen;
        n.tx_bit = s.tx_bit + 3'h1;
        n.tx_line = s.tx_sh[n.tx_bit];
        if (s.tx_bit == wl) begin
          n.tx_st = UFC_STOP;
          n.tx_line = 1'b1;
        end
      end
      UFC_STOP: if (s.tx_bc == '0) begin
        n.tx_st = UFC_IDLE;
      end
    endcase

    // FIFO storage and levels
    if (rx_push) begin
      n.rx_mem[s.rx_wr] = rx_ent;
      n.rx_wr = s.rx_wr + AW'(1);
    end
    if (rx_pop) begin
      n.rx_rd = s.rx_rd + AW'(1);
    end
    n.rx_cnt = s.rx_cnt + (AW + 1)'(rx_push) - (AW + 1)'(rx_pop);
    if (tx_push) begin
      n.tx_mem[s.tx_wr] = 8'(hwdata);
      n.tx_wr = s.tx_wr + AW'(1);
    end
    if (tx_pop) begin
      n.tx_rd = s.tx_rd + AW'(1);
    end
    n.tx_cnt = s.tx_cnt + (AW + 1)'(tx_push) - (AW + 1)'(tx_pop);
    if (s.ap_valid && s.ap_write && hready && s.ap_addr == UFC_A_IIR) begin
      if (hwdata[UFC_FCR_RXCLR]) begin
        n.rx_rd = '0;
        n.rx_wr = '0;
        n.rx_cnt = '0;
      end
      if (hwdata[UFC_FCR_TXCLR]) begin
        n.tx_rd = '0;
        n.tx_wr = '0;
        n.tx_cnt = '0;
      end
    end

    // CTS/RTS going inactive; CTS ignored while it throttles internally
    if ((s.cts_s[1] && !s.cts_q && !s.enhanced_feature_ctrl[UFC_EFR_ACTS])
        || (n.rts_n && !s.rts_n)) begin
      n.cts_flag = 1'b1;
    end
    n.irq = (n.xoff_flag && s.interrupt_enable_ctrl[UFC_IER_XOFF])
            || (n.cts_flag && s.interrupt_enable_ctrl[UFC_IER_CTSRTS]);
    n.rxr_n = !(rx_lvl >= trig(s.fifo_en, s.fifo_level_select[7:4]));
    n.txr_n = !(s.fifo_en ? (cap - 8'(s.tx_cnt)) >= trig(1'b1, s.fifo_level_select[3:0])
                          : s.tx_cnt == '0);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.rx_s <= 2'h3;
      s.cts_s <= 2'h3;
      s.cts_q <= 1'b1;
      s.tx_line <= 1'b1;
      s.rts_on <= 1'b1;
      s.rts_n <= 1'b1;
      s.rxr_n <= 1'b1;
      s.txr_n <= 1'b0;
    end else begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_RTS_HALT: assert property (s.enhanced_feature_ctrl[UFC_EFR_ARTS] && rx_lvl >= halt_lvl
    |=> !s.rts_on ##1 request_to_send_n) else $error("auto RTS not dropped at halt");
  AST_RTS_RESUME: assert property (rx_lvl <= resume_lvl && rx_lvl < halt_lvl
    |=> s.rts_on) else $error("auto RTS not restored at resume");
  AST_CTS_GATE: assert property (s.tx_st == UFC_IDLE && s.enhanced_feature_ctrl[UFC_EFR_ACTS]
    && s.cts_s[1] |=> s.tx_st == UFC_IDLE) else $error("character started with CTS high");
  AST_CTS_NOIRQ: assert property (s.enhanced_feature_ctrl[UFC_EFR_ACTS] && !(n.rts_n && !s.rts_n)
    |=> !$rose(s.cts_flag)) else $error("CTS change flagged under auto CTS");
  AST_NOCTS_SEND: assert property (s.tx_st == UFC_IDLE && !s.enhanced_feature_ctrl[UFC_EFR_ACTS]
    && s.tx_cnt != '0 && !tx_block |=> s.tx_st == UFC_START)
    else $error("queued data not sent without auto CTS");
  AST_XOFF_HALT: assert property (rx_done && xoff_hit |=> tx_block)
    else $error("pause character did not halt transmit");
  AST_XON_CLEAR: assert property (rx_done && xon_hit |=> !s.sw_halt && !s.xoff_flag)
    else $error("resume character did not restart");
  AST_SPECIAL: assert property (rx_done && special && s.interrupt_enable_ctrl[UFC_IER_XOFF]
    |-> rx_push || rx_lvl >= cap ##1 s.xoff_flag && s.sw_halt == $past(s.sw_halt))
    else $error("special character mishandled");
  AST_XOFF_SEND: assert property (s.enhanced_feature_ctrl[3:2] != 2'b00 && !s.xoff_sent
    && rx_lvl > halt_lvl |=> s.fl_pend == UFC_FL_XOFF) else $error("pause not queued");
endmodule

// file: hdl/ufc_pkg.sv
/*
  Shared constants and types for the serial channel flow-control block:
  register byte offsets, control bit positions, identification codes,
  timing constants and the packed records carried between parts.
  Assumes a 32-bit AHB-Lite slave port with one aligned word per register.
*/
package ufc_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] UFC_A_DATA = 8'h00;
  localparam logic [7:0] UFC_A_IER = 8'h04;
  localparam logic [7:0] UFC_A_IIR = 8'h08;
  localparam logic [7:0] UFC_A_LCR = 8'h0c;
  localparam logic [7:0] UFC_A_MCR = 8'h10;
  localparam logic [7:0] UFC_A_EFR = 8'h14;
  localparam logic [7:0] UFC_A_TCR = 8'h18;
  localparam logic [7:0] UFC_A_TLR = 8'h1c;
  localparam logic [7:0] UFC_A_DIV = 8'h20;
  localparam logic [7:0] UFC_A_CHR = 8'h24;
  localparam logic [7:0] UFC_A_STAT = 8'h28;
  ////////////////////////////////////////////////////////////////////////////
  // control bit positions
  localparam int UFC_IER_XOFF = 5;
  localparam int UFC_IER_CTSRTS = 7;
  localparam int UFC_FCR_EN = 0;
  localparam int UFC_FCR_RXCLR = 1;
  localparam int UFC_FCR_TXCLR = 2;
  localparam int UFC_MCR_RTS = 1;
  localparam int UFC_MCR_XANY = 5;
  localparam int UFC_EFR_SPECIAL = 5;
  localparam int UFC_EFR_ARTS = 6;
  localparam int UFC_EFR_ACTS = 7;
  // identification codes
  localparam logic [7:0] UFC_IIR_NONE = 8'h01;
  localparam logic [7:0] UFC_IIR_XOFF = 8'h10;
  localparam logic [7:0] UFC_IIR_CTSRTS = 8'h20;
  // bus and timing constants
  localparam logic [1:0] UFC_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] UFC_HSIZE_WORD = 3'h2;
  localparam int UFC_BCW = 20;
  localparam int UFC_OS_SHIFT = 4;
  localparam logic [15:0] UFC_DIV_MIN = 16'h0001;
  localparam int UFC_LVL_SHIFT = 2;
  localparam logic [2:0] UFC_WL_BASE = 3'h4;
  localparam logic [7:0] UFC_TRIG_ONE = 8'h01;
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic err_break;
    logic err_frame;
    logic err_parity;
    logic [7:0] data;
  } ufc_rx_entry_t;
  typedef struct packed {
    logic [7:0] pause_char_second;
    logic [7:0] pause_char_first;
    logic [7:0] resume_char_second;
    logic [7:0] resume_char_first;
  } ufc_chars_t;
  typedef struct packed {
    logic [12:0] unused;
    logic rts_pin_n;
    logic cts_pin_n;
    logic tx_halted;
    logic [7:0] tx_level;
    logic [7:0] rx_level;
  } ufc_stat_t;
  typedef enum logic [1:0] {UFC_IDLE, UFC_START, UFC_DATA, UFC_STOP} ufc_ser_t;
  typedef enum logic [1:0] {UFC_FL_NONE, UFC_FL_XOFF, UFC_FL_XON} ufc_flow_t;
endpackage

// file: verification/ufc_remote_model.sv
/*
  Remote serial partner: frames characters onto the channel's receive
  line and collects what the channel transmits.
  Assumes nbits data bits when collecting (8 unless the bench lowers it),
  no parity, one stop bit, BIT_CYC hclk per bit.
*/
`timescale 1ns/1ps
module ufc_remote_model #(
  parameter int BIT_CYC = 16
) (
  input wire logic hclk,
  input wire logic line_in,
  output logic line_out
);
  logic [7:0] got [$];
  logic [7:0] sh;
  int nbits = 8;
  initial line_out = 1'b1;
  //////////////////////////////////////////////////////////////////////
  // ignores rts, so one more character may follow a halt
  task automatic send(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    @(posedge hclk);
    for (int i = 0; i < 10; i++) begin
      line_out <= f[i];
      repeat (BIT_CYC) @(posedge hclk);
    end
  endtask
  // mid-bit sampling; a low glitch under half a bit is no start
  always begin
    @(negedge line_in);
    repeat (BIT_CYC / 2) @(posedge hclk);
    if (line_in === 1'b0) begin
      // short words: stop right after the last data bit, or the next start is missed
      sh = '0;
      for (int i = 0; i < nbits; i++) begin
        repeat (BIT_CYC) @(posedge hclk);
        sh[i] = line_in;
      end
      repeat (BIT_CYC) @(posedge hclk);
      got.push_back(sh);
    end
  end
endmodule

// file: verification/testbench.sv
/*
  Self-checking bench for the flow-control channel: AHB-Lite tasks,
  remote serial partner, random data among hand-picked corners.
  Assumes divisor 1 (16 hclk per bit) and a single bus slave.
*/
`timescale 1ns/1ps
module testbench import ufc_pkg::*;;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rx_in, tx_out;
  logic clear_to_send_n, request_to_send_n, channel_irq, rx_ready_n, tx_ready_n;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize, bus_size;
  logic [7:0] c [9];
  int error_cnt, cmp_count;
  ufc_flow_ctrl #(.FIFO_DEPTH(64)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rx_in(rx_in),
    .clear_to_send_n(clear_to_send_n), .tx_out(tx_out),
    .request_to_send_n(request_to_send_n), .channel_irq(channel_irq),
    .rx_ready_n(rx_ready_n), .tx_ready_n(tx_ready_n));
  ufc_remote_model rem_u (.hclk(hclk), .line_in(tx_out), .line_out(rx_in));
  //////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  // hang guard, well past the expected run
  initial begin
    #(25 * 60000);
    error_cnt++;
    results();
  end
  //////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("compares=%0d errors=%0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // ready and read data are taken at the rising edge, before it updates them
  task automatic rdy(output logic [31:0] d);
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= UFC_HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= bus_size;
    rdy(r);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy(r);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  task automatic settle;
    repeat (8) @(negedge hclk);
  endtask
  task automatic exp_rx(input logic [7:0] e);
    for (int n = 0; n < 400 && rem_u.got.size() == 0; n++) @(posedge hclk);
    if (rem_u.got.size() == 0) chk(32'hdead, {24'h0, e});
    else chk({24'h0, rem_u.got.pop_front()}, {24'h0, e});
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    {hsel, hwrite, haddr, hwdata, htrans, hsize} = '0;
    bus_size = UFC_HSIZE_WORD;
    clear_to_send_n = 1'b1;
    hresetn = 1'b0;
    void'($urandom(32'h7dd9));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    settle();
    chk(request_to_send_n, 1'b1);
    chk(tx_ready_n, 1'b0);
    rdc(UFC_A_IIR, {24'h0, UFC_IIR_NONE});
    rdc(UFC_A_EFR, 32'h0);
    chk(hresp, 1'b0);
    rdc(8'h3c, 32'h0);
    wr(UFC_A_DIV, 32'hffff);
    rdc(UFC_A_DIV, 32'hffff);
    // a byte-sized write must leave the divisor alone
    bus_size = 3'h0;
    wr(UFC_A_DIV, 32'h1234);
    bus_size = UFC_HSIZE_WORD;
    rdc(UFC_A_DIV, 32'hffff);
    wr(UFC_A_DIV, 32'h1);
    wr(UFC_A_LCR, 32'h3);
    wr(UFC_A_MCR, 32'h2);
    settle();
    chk(request_to_send_n, 1'b0);
    // fifo still off: one character reaches the trigger
    c[0] = $urandom;
    rem_u.send(c[0]);
    settle();
    chk(rx_ready_n, 1'b0);
    rdc(UFC_A_DATA, {24'h0, c[0]});
    wr(UFC_A_IIR, 32'h1);
    // cts high but ignored without auto cts
    for (int i = 0; i < 3; i++) begin
      c[i] = $urandom;
      wr(UFC_A_DATA, {24'h0, c[i]});
    end
    for (int i = 0; i < 3; i++) exp_rx(c[i]);
    // auto cts holds the character until cts drops
    wr(UFC_A_IER, 32'h80);
    wr(UFC_A_EFR, 32'h80);
    wr(UFC_A_DATA, {24'h0, c[1]});
    repeat (400) @(negedge hclk);
    chk(rem_u.got.size(), 32'h0);
    @(posedge hclk);
    clear_to_send_n <= 1'b0;
    exp_rx(c[1]);
    repeat (20) @(posedge hclk);
    clear_to_send_n <= 1'b1;
    settle();
    chk(channel_irq, 1'b0);
    @(posedge hclk);
    clear_to_send_n <= 1'b0;
    wr(UFC_A_IER, 32'h0);
    // auto rts: halt at 8, resume at 4, one extra char kept
    wr(UFC_A_EFR, 32'h40);
    wr(UFC_A_TCR, 32'h12);
    for (int i = 0; i < 9; i++) c[i] = $urandom;
    for (int i = 0; i < 8; i++) rem_u.send(c[i]);
    settle();
    chk(request_to_send_n, 1'b1);
    rem_u.send(c[8]);
    settle();
    rdc(UFC_A_STAT, 32'h0004_0009);
    for (int i = 0; i < 9; i++) begin
      rdc(UFC_A_DATA, {24'h0, c[i]});
      if (i == 3 || i == 4) begin
        settle();
        chk(request_to_send_n, i == 3);
      end
    end
    // special character flags but is stored
    wr(UFC_A_EFR, 32'h20);
    wr(UFC_A_IER, 32'h20);
    wr(UFC_A_CHR, 32'h9613_1211);
    rem_u.send(8'h96);
    settle();
    chk(channel_irq, 1'b1);
    rdc(UFC_A_IIR, {24'h0, UFC_IIR_XOFF});
    settle();
    chk(channel_irq, 1'b0);
    rdc(UFC_A_DATA, 32'h96);
    // pause halts the transmitter, resume restarts it
    wr(UFC_A_EFR, 32'h02);
    rem_u.send(8'h13);
    settle();
    chk(channel_irq, 1'b1);
    wr(UFC_A_DATA, {24'h0, c[0]});
    repeat (320) @(negedge hclk);
    chk(rem_u.got.size(), 32'h0);
    rem_u.send(8'h11);
    exp_rx(c[0]);
    chk(channel_irq, 1'b0);
    // resume on any character
    wr(UFC_A_MCR, 32'h22);
    rem_u.send(8'h13);
    wr(UFC_A_DATA, {24'h0, c[1]});
    rdc(UFC_A_STAT, 32'h0001_0100);
    rem_u.send(8'h41);
    exp_rx(c[1]);
    wr(UFC_A_MCR, 32'h2);
    // 5-bit words, both pairs sent at halt 4 and resume 0
    wr(UFC_A_LCR, 32'h0);
    rem_u.nbits = 5;
    wr(UFC_A_EFR, 32'h0c);
    wr(UFC_A_TCR, 32'h01);
    for (int i = 0; i < 5; i++) begin
      c[i] = $urandom | 8'he0;
      rem_u.send(c[i]);
    end
    exp_rx(8'h13);
    exp_rx(8'h16);
    for (int i = 0; i < 5; i++) rdc(UFC_A_DATA, {27'h0, c[i][4:0]});
    exp_rx(8'h11);
    exp_rx(8'h12);
    results();
  end
endmodule
